// File: sim/csp_alu_model.sv
// arithmetic unit model: multiplies by the operand register
// assumes go_in is a one-cycle pulse; lat_in adds wait cycles
`timescale 1ns/1ps
module csp_alu_model (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // request
  input  wire logic        go_in,
  input  wire logic [1:0]  lat_in,
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] operand_in,
  // result
  output logic             valid_out,
  output logic      [31:0] result_out
);
  logic        busy_r;
  logic [1:0]  wait_r;
  logic [15:0] a_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r     <= 1'b0;
      wait_r     <= 2'h0;
      a_r        <= 16'h0;
      valid_out  <= 1'b0;
      result_out <= 32'h0;
    end else begin
      valid_out  <= 1'b0;
      // idle result bus alternates between the last product and its complement
      result_out <= ~result_out;
      if (go_in) begin
        busy_r <= 1'b1;
        wait_r <= lat_in;
        a_r    <= a_in;
      end else if (busy_r && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (busy_r) begin
        busy_r     <= 1'b0;
        valid_out  <= 1'b1;
        result_out <= $signed(a_r) * $signed(operand_in);
      end
    end
  end
endmodule

// File: sim/csp_core_assertions.sv
// concurrent checks on the ports of the status/product path
// assumes binding into csp_core, one clock ref_clk_in, reset rst_n_in
`timescale 1ns/1ps
module csp_core_assertions
  import csp_pkg::*;
(
  // clock and reset
  input wire logic                     ref_clk_in,
  input wire logic                     rst_n_in,
  // strobes
  input wire logic                     int_ack_in,
  input wire logic                     trap_taken_in,
  input wire logic                     alu_overflow_in,
  input wire logic                     ov_branch_in,
  input wire logic                     load_st0_in,
  input wire logic                     load_st1_in,
  input wire logic                     set_ctl_in,
  input wire logic                     clr_ctl_in,
  input wire csp_pkg::csp_ctl_bit_type ctl_sel_in,
  // outputs watched
  input wire logic [15:0]              st0_out,
  input wire logic [15:0]              st1_out,
  input wire logic [15:0]              operand_out,
  input wire logic [3:0]               shift_count_out,
  input wire logic [3:0]               bit_index_out,
  input wire logic [15:0]              direct_addr_out,
  input wire logic [2:0]               aux_sel_out,
  input wire logic                     ext_flag_out,
  input wire logic                     sign_extend_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // outputs settled after reset
  sequence s_settled;
    rst_n_in && $past(rst_n_in, 2);
  endsequence
  sequence s_xf_set;
    set_ctl_in && !clr_ctl_in && !load_st1_in && ctl_sel_in == CSP_BIT_XF;
  endsequence
  sequence s_ov_clear;
    ov_branch_in && !alu_overflow_in && !load_st0_in;
  endsequence

  chk_reserved_ones: assert property (s_settled |-> st0_out[10] && (st1_out & 16'h01ec) == 16'h01ec)
    else $error("reserved status bits not one");
  chk_ack_disables: assert property (int_ack_in |-> ##2 st0_out[9])
    else $error("ack did not set interrupt disable");
  chk_trap_disables: assert property (trap_taken_in |-> ##2 st0_out[9])
    else $error("trap did not set disable");
  chk_load_keeps_global_int_disable: assert property (load_st0_in && !int_ack_in && !trap_taken_in && !set_ctl_in && !clr_ctl_in
    |-> ##2 $stable(st0_out[9]))
    else $error("load changed interrupt disable");
  chk_ov_latches: assert property (alu_overflow_in |-> ##2 st0_out[12])
    else $error("overflow not latched");
  chk_ov_holds: assert property ($fell(st0_out[12]) |-> $past(ov_branch_in, 2) || $past(load_st0_in, 2))
    else $error("overflow dropped without clear");
  chk_ov_clears: assert property (s_ov_clear |-> ##2 !st0_out[12])
    else $error("overflow not cleared by branch");
  chk_page_addr: assert property (s_settled |-> direct_addr_out[15:7] == st0_out[8:0])
    else $error("direct address page mismatch");
  chk_shift_index: assert property (s_settled |->
    shift_count_out == operand_out[3:0] && bit_index_out == 4'hf - operand_out[3:0])
    else $error("shift count or index mismatch");
  chk_mirror_flags: assert property (s_settled |->
    aux_sel_out == st0_out[15:13] && ext_flag_out == st1_out[4] && sign_extend_out == st1_out[10])
    else $error("field outputs disagree with status");
  chk_xf_set: assert property (s_xf_set |-> ##2 ext_flag_out && st1_out[4])
    else $error("flag pin not set");
endmodule

bind csp_core csp_core_assertions chk (
  .ref_clk_in, .rst_n_in, .int_ack_in, .trap_taken_in, .alu_overflow_in, .ov_branch_in, .load_st0_in,
  .load_st1_in, .set_ctl_in, .clr_ctl_in, .ctl_sel_in, .st0_out, .st1_out, .operand_out, .shift_count_out,
  .bit_index_out, .direct_addr_out, .aux_sel_out, .ext_flag_out, .sign_extend_out
);

// File: sim/csp_core_tb.sv
// self-checking bench for the status/product path
// assumes csp_core and the arithmetic unit model; strobes driven at falling edges
`timescale 1ns/1ps
module testbench;
  import csp_pkg::*;
  logic               ref_clk_in = 1'b0;
  logic               rst_n_in;
  logic               mult_valid_in, operand_load_in, load_st0_in, load_st1_in, set_ctl_in, clr_ctl_in;
  logic               pm_load_in, arp_load_in, arp_no_save_in, dp_load_in, alu_is_sub_in, alu_carry_in;
  logic               carry_force_in, alu_overflow_in, ov_branch_in, test_flag_load_in, test_flag_in;
  logic               maskable_req_in, int_ack_in, trap_taken_in, stack_push_in, stack_pop_in, mul_go;
  logic [31:0]        mult_result_in, product_scaled_out;
  logic [15:0]        operand_data_in, load_data_in, instr_word_in, stack_data_in, mul_a, e0, e1;
  logic [15:0]        st0_out, st1_out, operand_out, direct_addr_out, stack_top_out;
  logic [8:0]         dp_data_in;
  logic [3:0]         shift_count_out, bit_index_out;
  logic [2:0]         arp_data_in, aux_sel_out, old_arp;
  logic [1:0]         mul_lat;
  logic               maskable_accept_out, saturate_out, sign_extend_out, ram_in_prog_out, ext_flag_out;
  logic signed [31:0] prod;
  csp_ctl_bit_type    ctl_sel_in;
  csp_pm_type         pm_data_in;
  csp_carry_mode_type carry_mode_in;
  int                 error_cnt = 0;
  int                 n_compared = 0;
  int                 cycles = 0;
  // {word, bit} of each control bit, in enum order
  logic [4:0]         bmap [7] = '{5'h0b, 5'h09, 5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h14};
  // {mode, sub, carry, force, expected}
  logic [5:0]         cy_tab [11] = '{6'b010101, 6'b010000, 6'b011101, 6'b011000, 6'b100000, 6'b100101,
                                      6'b101101, 6'b101000, 6'b110011, 6'b110000, 6'b000110};
  // {no save, pointer}
  logic [3:0]         arp_tab [3] = '{4'h2, 4'h7, 4'h9};

  csp_core dut (.*);
  csp_alu_model partner (.ref_clk_in, .rst_n_in, .go_in(mul_go), .lat_in(mul_lat), .a_in(mul_a),
                         .operand_in(operand_out), .valid_out(mult_valid_in), .result_out(mult_result_in));

  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_st();
    cmp_val(st0_out, e0);
    cmp_val(st1_out, e1);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, errors %0d", name, error_cnt);
  endtask

  task automatic idle();
    {operand_load_in, load_st0_in, load_st1_in, set_ctl_in, clr_ctl_in, pm_load_in, arp_load_in} = '0;
    {dp_load_in, alu_overflow_in, ov_branch_in, test_flag_load_in, int_ack_in, trap_taken_in} = '0;
    {stack_push_in, stack_pop_in} = '0;
    carry_mode_in = CSP_CARRY_NONE;
  endtask

  // caller strobes taken, outputs settle
  task automatic fire();
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    idle();
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    idle();
    {arp_no_save_in, alu_is_sub_in, alu_carry_in, carry_force_in, test_flag_in, maskable_req_in, mul_go} = '0;
    {operand_data_in, load_data_in, instr_word_in, stack_data_in, mul_a} = '0;
    {dp_data_in, arp_data_in, mul_lat} = '0;
    ctl_sel_in = CSP_BIT_OVM;
    pm_data_in = CSP_PM_NONE;
    e0 = 16'h0600;
    e1 = 16'h07fc;
    repeat (6) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
  endtask

  initial begin
    do_reset();
    chk_st();
    cmp_flag(sign_extend_out, 1'b1);
    cmp_flag(ext_flag_out, 1'b1);
    cmp_flag(ram_in_prog_out, 1'b0);
    end_test("reset");
    operand_data_in = 16'h8003;
    operand_load_in = 1'b1;
    fire();
    cmp_val({operand_out, shift_count_out, bit_index_out}, {16'h8003, 4'h3, 4'hc});
    for (int i = 0; i < 4; i++) begin
      pm_data_in = csp_pm_type'(i);
      pm_load_in = 1'b1;
      fire();
      mul_a = 16'h0005 + 16'(i);
      mul_lat = 2'(i);
      mul_go = 1'b1;
      @(negedge ref_clk_in);
      mul_go = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      prod = $signed(mul_a) * $signed(operand_data_in);
      cmp_val(st1_out, e1 | 16'(i));
      cmp_val(product_scaled_out, (i == 0) ? prod : (i == 1) ? prod <<< 1 : (i == 2) ? prod <<< 4 : prod >>> 6);
    end
    pm_data_in = CSP_PM_NONE;
    pm_load_in = 1'b1;
    fire();
    end_test("product");
    load_data_in = 16'ha000;
    load_st1_in = 1'b1;
    fire();
    e0 = 16'ha600;
    e1 = 16'ha1ec;
    chk_st();
    cmp_flag(sign_extend_out, 1'b0);
    for (int s = 0; s < 7; s++) begin
      ctl_sel_in = csp_ctl_bit_type'(s);
      for (int v = 1; v >= 0; v--) begin
        if (v == 1) set_ctl_in = 1'b1;
        else clr_ctl_in = 1'b1;
        fire();
        if (bmap[s][4]) e1[bmap[s][3:0]] = v[0];
        else e0[bmap[s][3:0]] = v[0];
        chk_st();
        if (s == 2) cmp_flag(ram_in_prog_out, v[0]);
      end
    end
    end_test("set_clear");
    maskable_req_in = 1'b1;
    load_data_in = 16'hbe55;
    load_st0_in = 1'b1;
    fire();
    e0 = 16'hbc55;
    chk_st();
    cmp_flag(saturate_out, 1'b1);
    cmp_flag(maskable_accept_out, 1'b1);
    instr_word_in = 16'hff2a;
    dp_data_in = 9'h1a3;
    dp_load_in = 1'b1;
    test_flag_in = 1'b1;
    test_flag_load_in = 1'b1;
    fire();
    e0[8:0] = 9'h1a3;
    e1[11] = 1'b1;
    chk_st();
    cmp_val(direct_addr_out, {9'h1a3, 7'h2a});
    ov_branch_in = 1'b1;
    fire();
    e0[12] = 1'b0;
    chk_st();
    alu_overflow_in = 1'b1;
    ov_branch_in = 1'b1;
    fire();
    repeat (3) @(negedge ref_clk_in);
    e0[12] = 1'b1;
    chk_st();
    end_test("status_load");
    int_ack_in = 1'b1;
    fire();
    e0[9] = 1'b1;
    chk_st();
    cmp_flag(maskable_accept_out, 1'b0);
    trap_taken_in = 1'b1;
    clr_ctl_in = 1'b1;
    ctl_sel_in = CSP_BIT_GLOBAL_INT_DISABLE;
    fire();
    chk_st();
    clr_ctl_in = 1'b1;
    fire();
    e0[9] = 1'b0;
    cmp_flag(maskable_accept_out, 1'b1);
    end_test("interrupt_disable");
    foreach (arp_tab[j]) begin
      {arp_no_save_in, arp_data_in} = arp_tab[j];
      arp_load_in = 1'b1;
      fire();
      old_arp = e0[15:13];
      e0[15:13] = arp_tab[j][2:0];
      if (!arp_tab[j][3]) e1[15:13] = old_arp;
      chk_st();
    end
    arp_no_save_in = 1'b0;
    foreach (cy_tab[t]) begin
      carry_mode_in = csp_carry_mode_type'(cy_tab[t][5:4]);
      {alu_is_sub_in, alu_carry_in, carry_force_in} = cy_tab[t][3:1];
      fire();
      e1[9] = cy_tab[t][0];
      chk_st();
    end
    end_test("pointer_carry");
    for (int k = 0; k < 8; k++) begin
      stack_data_in = 16'h1000 + 16'(k) * 16'h0111;
      stack_push_in = 1'b1;
      fire();
      cmp_val(stack_top_out, stack_data_in);
    end
    for (int k = 6; k >= 0; k--) begin
      stack_pop_in = 1'b1;
      fire();
      cmp_val(stack_top_out, 16'h1000 + 16'(k) * 16'h0111);
    end
    end_test("stack");
    do_reset();
    chk_st();
    end_test("second_reset");
    tally_and_finish();
  end
endmodule

// File: src/csp_cfg.svh
// status/product path constants: field positions, reset values, stack depth
// assumes inclusion by the package and the modules of this block
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_ARP_HI        15
`define CSP_ARP_LO        13
`define CSP_OV_BIT        12
`define CSP_OVM_BIT       11
`define CSP_ST0_RSV_BIT   10
`define CSP_GLOBAL_INT_DISABLE_BIT      9
`define CSP_DP_HI         8
`define CSP_ARB_HI        15
`define CSP_ARB_LO        13
`define CSP_CNF_BIT       12
`define CSP_TC_BIT        11
`define CSP_SXM_BIT       10
`define CSP_C_BIT         9
`define CSP_XF_BIT        4
`define CSP_ST1_RSV_MASK  16'h01ec
`define CSP_ST0_RSV_MASK  16'h0400
`define CSP_STACK_DEPTH   8
`define CSP_PM_RESET      2'h0
`define CSP_ADDR_LOW_BITS 7
`endif

// File: src/csp_core.sv
// Function
// - 32-bit product register holds each multiply result
// - scaler passes, shifts left 1/4, right 6
// - scaler is combinational, adds no cycle
// - eight-entry 16-bit hardware stack
// - operand register feeds multiplier, shift, bit index
// - reserved status bits read as one from the first clock after reset
// - status load/store; load keeps interrupt disable
// - set/clear control bit touches one bit
// - pointer load saves old pointer to buffer
// - status one load copies buffer to pointer
// - pointer updated by indirect, load, modify, status
// - carry: add carry sets, sub borrow clears
// - 16-bit shifted add sets, sub clears only
// - shifts, set/clear, load update carry; reset sets
// - RAM map select bit, reset clears
// - page pointer above seven low bits
// - interrupt disable blocks only maskable interrupts
// - reset, acknowledge, trap set interrupt disable
// - overflow latches until reset, branch, load
// - product shift select encoding, reset clears
// - saturate mode bit selects saturate or wrap
// - sign extend mode, reset sets
// - external flag drives pin, reset sets
//
// status words, product/operand registers, stack and scaler of the core
// assumes decoder strobes are one-cycle pulses on ref_clk_in
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_core (
  // clock and reset
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_n_in,
  // multiplier and operand
  input  wire logic                        mult_valid_in,
  input  wire logic [31:0]                 mult_result_in,
  input  wire logic                        operand_load_in,
  input  wire logic [15:0]                 operand_data_in,
  // status load/store and set/clear
  input  wire logic                        load_st0_in,
  input  wire logic                        load_st1_in,
  input  wire logic [15:0]                 load_data_in,
  input  wire logic                        set_ctl_in,
  input  wire logic                        clr_ctl_in,
  input  wire csp_pkg::csp_ctl_bit_type    ctl_sel_in,
  input  wire logic                        pm_load_in,
  input  wire csp_pkg::csp_pm_type         pm_data_in,
  // pointers
  input  wire logic                        arp_load_in,
  input  wire logic                        arp_no_save_in,
  input  wire logic [2:0]                  arp_data_in,
  input  wire logic                        dp_load_in,
  input  wire logic [8:0]                  dp_data_in,
  input  wire logic [15:0]                 instr_word_in,
  // arithmetic status
  input  wire csp_pkg::csp_carry_mode_type carry_mode_in,
  input  wire logic                        alu_is_sub_in,
  input  wire logic                        alu_carry_in,
  input  wire logic                        carry_force_in,
  input  wire logic                        alu_overflow_in,
  input  wire logic                        ov_branch_in,
  input  wire logic                        test_flag_load_in,
  input  wire logic                        test_flag_in,
  // interrupts
  input  wire logic                        maskable_req_in,
  input  wire logic                        int_ack_in,
  input  wire logic                        trap_taken_in,
  // stack
  input  wire logic                        stack_push_in,
  input  wire logic                        stack_pop_in,
  input  wire logic [15:0]                 stack_data_in,
  // outputs
  output logic      [15:0]                 st0_out,
  output logic      [15:0]                 st1_out,
  output logic      [31:0]                 product_scaled_out,
  output logic      [15:0]                 operand_out,
  output logic      [3:0]                  shift_count_out,
  output logic      [3:0]                  bit_index_out,
  output logic      [15:0]                 direct_addr_out,
  output logic      [2:0]                  aux_sel_out,
  output logic      [15:0]                 stack_top_out,
  output logic                             maskable_accept_out,
  output logic                             saturate_out,
  output logic                             sign_extend_out,
  output logic                             ram_in_prog_out,
  output logic                             ext_flag_out
);
  import csp_pkg::*;

  // status fields
  logic [2:0]  aux_reg_pointer_r;
  logic [2:0]  aux_pointer_buffer_r;
  logic        arith_excess_flag_r;
  logic        saturate_mode_r;
  logic        global_int_disable_r;
  logic [8:0]  page_pointer_r;
  logic        ram_map_select_r;
  logic        test_flag_r;
  logic        sign_extend_mode_r;
  logic        carry_r;
  logic        ext_flag_output_r;
  csp_pm_type  product_shift_select_r;
  logic [31:0] product_holding_reg_r;
  logic [15:0] multiplier_operand_reg_r;
  logic        carry_nxt;
  logic [31:0] scaled;

  csp_stack_if stk ();

  // one set/clear strobe decoded per bit
  function automatic logic ctl_hit(input csp_ctl_bit_type sel, input csp_ctl_bit_type b);
    ctl_hit = (sel == b);
  endfunction

  function automatic logic ctl_update(input logic cur, input csp_ctl_bit_type b,
                                      input logic set_p, input logic clr_p,
                                      input csp_ctl_bit_type sel);
    if (set_p && ctl_hit(sel, b)) begin
      ctl_update = 1'b1;
    end else if (clr_p && ctl_hit(sel, b)) begin
      ctl_update = 1'b0;
    end else begin
      ctl_update = cur;
    end
  endfunction

  // product and operand
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      product_holding_reg_r <= 32'h0000_0000;
    end else if (mult_valid_in) begin
      product_holding_reg_r <= mult_result_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      multiplier_operand_reg_r <= 16'h0000;
    end else if (operand_load_in) begin
      multiplier_operand_reg_r <= operand_data_in;
    end
  end

  csp_product_scaler u_product_scaler (
    .prod_in    (product_holding_reg_r),
    .pm_in      (product_shift_select_r),
    .scaled_out (scaled)
  );

  assign stk.push      = stack_push_in;
  assign stk.pop       = stack_pop_in & ~stack_push_in;
  assign stk.push_data = stack_data_in;

  csp_stack #(
    .DEPTH (`CSP_STACK_DEPTH)
  ) u_stack (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .st         (stk)
  );

  // auxiliary pointer and buffer
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aux_reg_pointer_r    <= 3'h0;
      aux_pointer_buffer_r <= 3'h0;
    end else if (load_st1_in) begin
      aux_pointer_buffer_r <= load_data_in[`CSP_ARB_HI:`CSP_ARB_LO];
      aux_reg_pointer_r    <= load_data_in[`CSP_ARB_HI:`CSP_ARB_LO];
    end else if (load_st0_in) begin
      aux_reg_pointer_r    <= load_data_in[`CSP_ARP_HI:`CSP_ARP_LO];
    end else if (arp_load_in) begin
      aux_reg_pointer_r    <= arp_data_in;
      if (!arp_no_save_in) begin
        aux_pointer_buffer_r <= aux_reg_pointer_r;
      end
    end
  end

  // page pointer
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_pointer_r <= 9'h000;
    end else if (load_st0_in) begin
      page_pointer_r <= load_data_in[`CSP_DP_HI:0];
    end else if (dp_load_in) begin
      page_pointer_r <= dp_data_in;
    end
  end

  // overflow: event beats clearing
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arith_excess_flag_r <= 1'b0;
    end else if (alu_overflow_in) begin
      arith_excess_flag_r <= 1'b1;
    end else if (load_st0_in) begin
      arith_excess_flag_r <= load_data_in[`CSP_OV_BIT];
    end else if (ov_branch_in) begin
      arith_excess_flag_r <= 1'b0;
    end
  end

  // interrupt disable: load leaves it alone; hardware set wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_int_disable_r <= 1'b1;
    end else if (int_ack_in || trap_taken_in) begin
      global_int_disable_r <= 1'b1;
    end else begin
      global_int_disable_r <= ctl_update(global_int_disable_r, CSP_BIT_GLOBAL_INT_DISABLE,
                                         set_ctl_in, clr_ctl_in, ctl_sel_in);
    end
  end

  // mode bits of status word zero and one
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      saturate_mode_r    <= 1'b0;
      ram_map_select_r   <= 1'b0;
      sign_extend_mode_r <= 1'b1;
      ext_flag_output_r  <= 1'b1;
    end else begin
      if (load_st0_in) begin
        saturate_mode_r <= load_data_in[`CSP_OVM_BIT];
      end else begin
        saturate_mode_r <= ctl_update(saturate_mode_r, CSP_BIT_OVM, set_ctl_in, clr_ctl_in, ctl_sel_in);
      end
      if (load_st1_in) begin
        ram_map_select_r   <= load_data_in[`CSP_CNF_BIT];
        sign_extend_mode_r <= load_data_in[`CSP_SXM_BIT];
        ext_flag_output_r  <= load_data_in[`CSP_XF_BIT];
      end else begin
        ram_map_select_r   <= ctl_update(ram_map_select_r, CSP_BIT_CNF, set_ctl_in, clr_ctl_in, ctl_sel_in);
        sign_extend_mode_r <= ctl_update(sign_extend_mode_r, CSP_BIT_SXM, set_ctl_in, clr_ctl_in, ctl_sel_in);
        ext_flag_output_r  <= ctl_update(ext_flag_output_r, CSP_BIT_XF, set_ctl_in, clr_ctl_in, ctl_sel_in);
      end
    end
  end

  // product shift select
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      product_shift_select_r <= csp_pm_type'(`CSP_PM_RESET);
    end else if (load_st1_in) begin
      product_shift_select_r <= csp_pm_type'(load_data_in[1:0]);
    end else if (pm_load_in) begin
      product_shift_select_r <= pm_data_in;
    end
  end

  // test flag
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      test_flag_r <= 1'b0;
    end else if (test_flag_load_in) begin
      test_flag_r <= test_flag_in;
    end else if (load_st1_in) begin
      test_flag_r <= load_data_in[`CSP_TC_BIT];
    end else begin
      test_flag_r <= ctl_update(test_flag_r, CSP_BIT_TC, set_ctl_in, clr_ctl_in, ctl_sel_in);
    end
  end

  // carry next value
  always_comb begin
    carry_nxt = carry_r;
    case (carry_mode_in)
      CSP_CARRY_NORMAL: carry_nxt = alu_is_sub_in ? ~alu_carry_in ? 1'b0 : 1'b1
                                                  : alu_carry_in;
      CSP_CARRY_HI16: begin
        if (!alu_is_sub_in && alu_carry_in) begin
          carry_nxt = 1'b1;
        end else if (alu_is_sub_in && !alu_carry_in) begin
          carry_nxt = 1'b0;
        end
      end
      CSP_CARRY_FORCE:  carry_nxt = carry_force_in;
      default:          carry_nxt = carry_r;
    endcase
    if (load_st1_in) begin
      carry_nxt = load_data_in[`CSP_C_BIT];
    end else begin
      carry_nxt = ctl_update(carry_nxt, CSP_BIT_C, set_ctl_in, clr_ctl_in, ctl_sel_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carry_r <= 1'b1;
    end else begin
      carry_r <= carry_nxt;
    end
  end

  // registered outputs; scaled product passes without an added cycle
  assign product_scaled_out = scaled;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st0_out <= 16'h0000;
      st1_out <= 16'h0000;
    end else begin
      st0_out <= {aux_reg_pointer_r, arith_excess_flag_r, saturate_mode_r, 1'b0,
                  global_int_disable_r, page_pointer_r} | `CSP_ST0_RSV_MASK;
      st1_out <= {aux_pointer_buffer_r, ram_map_select_r, test_flag_r, sign_extend_mode_r,
                  carry_r, 4'h0, ext_flag_output_r, 2'h0, product_shift_select_r}
                 | `CSP_ST1_RSV_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      operand_out         <= 16'h0000;
      shift_count_out     <= 4'h0;
      bit_index_out       <= 4'h0;
      direct_addr_out     <= 16'h0000;
      aux_sel_out         <= 3'h0;
      stack_top_out       <= 16'h0000;
      maskable_accept_out <= 1'b0;
      saturate_out        <= 1'b0;
      sign_extend_out     <= 1'b1;
      ram_in_prog_out     <= 1'b0;
      ext_flag_out        <= 1'b1;
    end else begin
      operand_out         <= multiplier_operand_reg_r;
      shift_count_out     <= multiplier_operand_reg_r[3:0];
      bit_index_out       <= 4'hf - multiplier_operand_reg_r[3:0];
      direct_addr_out     <= {page_pointer_r, instr_word_in[`CSP_ADDR_LOW_BITS-1:0]};
      aux_sel_out         <= aux_reg_pointer_r;
      stack_top_out       <= stk.top_data;
      maskable_accept_out <= maskable_req_in & ~global_int_disable_r;
      saturate_out        <= saturate_mode_r;
      sign_extend_out     <= sign_extend_mode_r;
      ram_in_prog_out     <= ram_map_select_r;
      ext_flag_out        <= ext_flag_output_r;
    end
  end
endmodule

// File: src/csp_pkg.sv
// types of the status/product path
// assumes csp_cfg.svh is on the include path
`include "csp_cfg.svh"
package csp_pkg;
  typedef enum logic [1:0] {CSP_PM_NONE, CSP_PM_LEFT1, CSP_PM_LEFT4, CSP_PM_RIGHT6} csp_pm_type;
  typedef enum logic [3:0] {
    CSP_BIT_OVM, CSP_BIT_GLOBAL_INT_DISABLE, CSP_BIT_CNF, CSP_BIT_TC, CSP_BIT_SXM, CSP_BIT_C, CSP_BIT_XF
  } csp_ctl_bit_type;
  typedef enum logic [1:0] {CSP_CARRY_NONE, CSP_CARRY_NORMAL, CSP_CARRY_HI16, CSP_CARRY_FORCE} csp_carry_mode_type;
endpackage

// File: src/csp_product_scaler.sv
// product scaler, purely combinational
// assumes the shift selection is held in status word one
`timescale 1ns/1ps
module csp_product_scaler (
  // inputs
  input  wire logic [31:0]        prod_in,
  input  wire csp_pkg::csp_pm_type pm_in,
  // output
  output logic      [31:0]        scaled_out
);
  import csp_pkg::*;
  always_comb begin
    case (pm_in)
      CSP_PM_NONE:   scaled_out = prod_in;
      CSP_PM_LEFT1:  scaled_out = {prod_in[30:0], 1'b0};
      CSP_PM_LEFT4:  scaled_out = {prod_in[27:0], 4'h0};
      CSP_PM_RIGHT6: scaled_out = {{6{prod_in[31]}}, prod_in[31:6]};
      default:       scaled_out = prod_in;
    endcase
  end
endmodule

// File: src/csp_stack.sv
// eight-level, 16-bit hardware stack in flip-flops
// assumes push and pop come from the top, one per cycle
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_stack #(
  parameter int DEPTH = `CSP_STACK_DEPTH
) (
  // clock and reset
  input  wire logic  ref_clk_in,
  input  wire logic  rst_n_in,
  // stack port
  csp_stack_if.store st
);
  logic [15:0] level_r [DEPTH];

  assign st.top_data = level_r[0];

  // push shifts down, pop shifts up; bottom copies itself on pop
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_lvl
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          level_r[g] <= 16'h0000;
        end else if (st.push) begin
          level_r[g] <= (g == 0) ? st.push_data : level_r[(g == 0) ? 0 : g - 1];
        end else if (st.pop) begin
          level_r[g] <= level_r[(g == DEPTH - 1) ? g : g + 1];
        end
      end
    end
  endgenerate
endmodule

// File: src/csp_stack_if.sv
// carrier between the top and the eight-level stack
// assumes a single clock domain
`timescale 1ns/1ps
interface csp_stack_if;
  logic        push;
  logic        pop;
  logic [15:0] push_data;
  logic [15:0] top_data;
  modport owner (output push, pop, push_data, input top_data);
  modport store (input push, pop, push_data, output top_data);
endinterface
